//--- mpgt_gate_drv.sv
// Behavioural model of the four external gate drivers, timing every gate pulse.
`timescale 1ns/1ps
module mpgt_gate_drv (
  // Clock shared with the generator.
  input  wire logic             clk,
  // Gate drive lines, high means the switch is on.
  input  wire logic [3:0]       gate_in,
  // Measured low time, fall to fall period and last fall stamp per gate.
  output logic [3:0][31:0]      low_len,
  output logic [3:0][31:0]      period,
  output logic [3:0][31:0]      fall_at
);
  logic [31:0]      now;        // Free running cycle count.
  logic [3:0]       gate_last;  // Gate levels seen one cycle earlier.
  logic [3:0][31:0] low_run;    // Cycles spent low in the current window.

  // Everything starts cleared so that early reads are defined.
  initial begin
    now = '0;
    gate_last = 4'h0;
    low_run = '0;
    low_len = '0;
    period = '0;
    fall_at = '0;
  end

  // Sampling on the falling edge keeps clear of the generator's own updates.
  always @(negedge clk) begin
    now <= now + 32'h1;
    gate_last <= gate_in;
    for (int g = 0; g < 4; g++) begin
      if (gate_last[g] && !gate_in[g]) begin
        // A new off window begins, so one full period has passed.
        period[g] <= now - fall_at[g];
        fall_at[g] <= now;
        low_run[g] <= 32'h1;
      end else if (!gate_in[g]) begin
        // The switch is still held off.
        low_run[g] <= low_run[g] + 32'h1;
      end else if (!gate_last[g]) begin
        // The switch turned on again, so the window length is final.
        low_len[g] <= low_run[g];
      end
    end
  end
endmodule

//--- mpgt_loop.sv
// One regulation loop: clock divider, inter-phase delay and per-phase off windows.
`timescale 1ns/1ps
module mpgt_loop #(
  parameter int DIV_W = 8,  // Divisor field width.
  parameter int DLY_W = 5,  // Delay field width.
  parameter int OFF_W = 3   // Off-time field width.
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Timing configuration.
  input  wire logic [DIV_W-1:0] divisor,
  input  wire logic [DLY_W-1:0] delay,
  input  wire logic [OFF_W-1:0] off_time,
  input  wire logic [2:0]       phase_count,
  // Timing results.
  output logic [3:0]            phase_off,
  output logic                  div_tick
);

  // Off length: zero still gives one divided period.
  function automatic logic [OFF_W-1:0] off_len(input logic [OFF_W-1:0] t);
    off_len = (t == '0) ? {{(OFF_W-1){1'b0}}, 1'b1} : t;
  endfunction

  mpgt_pkg::mpgt_state_t state_reg, state_next;  // Sequencer state.
  logic [DIV_W-1:0] div_cnt_reg, div_cnt_next;    // Divider counter.
  logic [DLY_W-1:0] dly_cnt_reg, dly_cnt_next;    // Divided periods in the slot.
  logic [1:0]       cur_reg, cur_next;            // Current virtual phase.
  logic [OFF_W-1:0] off_reg [4];                  // Remaining off periods per phase.
  logic [OFF_W-1:0] off_next [4];                 // Next off counts.

  // Decodes of the running sequence.
  wire running   = (state_reg == mpgt_pkg::MPGT_RUN);
  wire slot_done = div_tick && (dly_cnt_reg == delay);
  wire last_ph   = ({1'b0, cur_reg} + 3'h1) >= phase_count;
  wire start_run = (state_reg == mpgt_pkg::MPGT_IDLE) && (phase_count != 3'h0);

  // The divided tick comes once every divisor plus one clocks.
  assign div_tick = running && (div_cnt_reg == divisor);

  // Next state, counters and phase pointer.
  always_comb begin
    state_next   = state_reg;
    div_cnt_next = div_tick ? '0 : div_cnt_reg + 1'b1;
    dly_cnt_next = div_tick ? (slot_done ? '0 : dly_cnt_reg + 1'b1) : dly_cnt_reg;
    cur_next     = slot_done ? (last_ph ? 2'h0 : cur_reg + 2'h1) : cur_reg;
    case (state_reg)
      mpgt_pkg::MPGT_IDLE: begin
        div_cnt_next = '0;
        dly_cnt_next = '0;
        cur_next     = 2'h0;
        if (start_run) begin
          state_next = mpgt_pkg::MPGT_RUN;
        end
      end
      mpgt_pkg::MPGT_RUN: begin
        if (phase_count == 3'h0) begin
          state_next = mpgt_pkg::MPGT_IDLE;
        end
      end
      default: begin
        state_next = mpgt_pkg::MPGT_IDLE;
      end
    endcase
  end

  // Off windows open at a slot start and count down on divided ticks only.
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      off_next[p] = off_reg[p];
      if (!running && !start_run) begin
        off_next[p] = '0;
      end else if (start_run && p == 0) begin
        off_next[p] = off_len(off_time);
      end else if (slot_done && cur_next == p[1:0]) begin
        off_next[p] = off_len(off_time);
      end else if (div_tick && off_reg[p] != '0) begin
        off_next[p] = off_reg[p] - 1'b1;
      end
    end
  end

  // State registers.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg   <= mpgt_pkg::MPGT_IDLE;
      div_cnt_reg <= '0;
      dly_cnt_reg <= '0;
      cur_reg     <= 2'h0;
      for (int p = 0; p < 4; p++) begin
        off_reg[p] <= '0;
      end
    end else begin
      state_reg   <= state_next;
      div_cnt_reg <= div_cnt_next;
      dly_cnt_reg <= dly_cnt_next;
      cur_reg     <= cur_next;
      for (int p = 0; p < 4; p++) begin
        off_reg[p] <= off_next[p];
      end
    end
  end

  // A phase is off while its window counter is non-zero.
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      phase_off[p] = (off_reg[p] != '0);
    end
  end

  // Helper: clocks since the last tick and ticks since the last slot start.
  logic [8:0] gap_reg;   // Clocks between divided ticks.
  logic [5:0] tks_reg;   // Divided ticks within a slot.
  logic       seen_reg;  // A full interval has been observed with stable settings.
  always_ff @(posedge clk) begin
    if (!rst_b || !running || !$stable(divisor) || !$stable(delay)) begin
      gap_reg  <= 9'h000;
      tks_reg  <= 6'h00;
      seen_reg <= 1'b0;
    end else begin
      gap_reg  <= div_tick ? 9'h001 : gap_reg + 9'h001;
      tks_reg  <= slot_done ? 6'h00 : (div_tick ? tks_reg + 6'h01 : tks_reg);
      seen_reg <= seen_reg | slot_done;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // A settings change mid-run makes the first interval a mix of old and new, so skip it.
  a_div_period: assert property (div_tick && seen_reg && $stable(divisor) |->
    gap_reg == {1'b0, divisor} + 9'h001)
    else $error("Divided tick period does not match divisor plus one.");
  a_delay_ticks: assert property (slot_done && seen_reg && $stable(delay) |->
    tks_reg == {1'b0, delay})
    else $error("Inter-phase delay does not match delay field plus one.");
  a_off_timebase: assert property (running && !div_tick && !start_run |=> $stable(phase_off))
    else $error("Off window changed without a divided tick.");
  a_off_opens: assert property (slot_done && phase_count != 3'h0 |=> phase_off[cur_reg])
    else $error("Off window did not open at slot start.");
  a_phase_wrap: assert property (slot_done && last_ph && running |=> cur_reg == 2'h0)
    else $error("Phase sequence did not wrap after the last phase.");
  c_wrap: cover property (slot_done && last_ph && phase_count == 3'h4);
  c_long_off: cover property (slot_done && off_time == 3'h7 && delay == 5'h1F);

endmodule

//--- mpgt_pkg.sv
// Shared register map, field layout, reset values and types of the phase timing generator.
package mpgt_pkg;

  // Register offsets on the serial register port.
  localparam logic [7:0] ADDR_GATE_EN   = 8'h01;  // Per-gate enable.
  localparam logic [7:0] ADDR_GATE_LOOP = 8'h02;  // Gate to loop association.
  localparam logic [7:0] ADDR_DIV1      = 8'h09;  // Loop 1 divisor.
  localparam logic [7:0] ADDR_DIV2      = 8'h0A;  // Loop 2 divisor.
  localparam logic [7:0] ADDR_TIME1     = 8'h0D;  // Loop 1 delay and off time.
  localparam logic [7:0] ADDR_TIME2     = 8'h0E;  // Loop 2 delay and off time.
  localparam logic [7:0] ADDR_PHSEL     = 8'h0F;  // Virtual phase select per gate.
  localparam logic [7:0] ADDR_STATUS    = 8'h1F;  // Read-only live gate state.

  // Field positions.
  localparam int GATE_MSB  = 3;  // Gate bits sit in 3 down to 0.
  localparam int DELAY_MSB = 7;  // Inter-phase delay field top bit.
  localparam int DELAY_LSB = 3;  // Inter-phase delay field low bit.
  localparam int OFF_MSB   = 2;  // Off-time field top bit.
  localparam int OFF_LSB   = 0;  // Off-time field low bit.

  // Values after reset: every gate disabled, fastest timing.
  localparam logic [7:0] RST_REG8  = 8'h00;  // Reset value of all registers.
  localparam logic [7:0] READ_NONE = 8'h00;  // Answer to unmapped addresses.

  // Number of physical and virtual phases.
  localparam int NUM_PHASES = 4;

  // Loop sequencer states, one-hot.
  typedef enum logic [1:0] {
    MPGT_IDLE = 2'b01,
    MPGT_RUN  = 2'b10
  } mpgt_state_t;

  // Counts the set bits of a four-bit gate mask.
  function automatic logic [2:0] mpgt_count4(input logic [3:0] mask);
    mpgt_count4 = {2'b00, mask[0]} + {2'b00, mask[1]} + {2'b00, mask[2]} + {2'b00, mask[3]};
  endfunction

endpackage

//--- mpgt_top.sv
// Top of the four-phase gate timing generator: registers, routing and gate outputs.
//
// What this block does
// - Gate enable bit one enables, zero disables.
// - All timing derives from one shared clock.
// - Loop 1 divides by divisor plus one.
// - Loop 2 divides by its divisor plus one.
// - Divided clock times each phase off window.
// - Divided clock times delay between phases.
// - Phase count times delay sets period.
// - Loop 1 delay is field plus one.
// - Loop 2 delay is field plus one.
// - Loop 1 off time, zero meaning one.
// - Loop 2 off time, zero meaning one.
// - Each gate follows one selected virtual phase.
// - Fail silent forces all gates off.
`timescale 1ns/1ps
module mpgt_top (
  // Clock and synchronous active-low reset.
  input  wire logic       CLK,
  input  wire logic       RST_B,
  // Register port from the serial interface decoder.
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  output logic [7:0]      REG_RDATA,
  // Fail silent request from the device supervisor.
  input  wire logic       FAIL_SILENT,
  // Gate drive outputs, high means the switch is on.
  output logic [3:0]      GATE_OUT
);

  // Configuration registers.
  logic [3:0] gate_phase_enable_reg;    // gate4_on..gate1_on.
  logic [3:0] gate_loop_reg;            // Zero puts the gate on loop 1.
  logic [7:0] loop1_clock_divider_reg;  // loop1_divisor.
  logic [7:0] loop2_clock_divider_reg;  // loop2_divisor.
  logic [7:0] loop1_offtime_delay_reg;  // Delay and off time of loop 1.
  logic [7:0] loop2_offtime_delay_reg;  // Delay and off time of loop 2.
  logic [7:0] phase_select_reg;         // Two bits per gate.
  logic [7:0] rdata_reg;                // Read answer.
  logic [3:0] gate_reg, gate_next;      // Gate drive flops.

  // The status register has no strobe, so a write there is simply ignored.
  // Write strobes per register.
  wire wr_en   = REG_WR && (REG_ADDR == mpgt_pkg::ADDR_GATE_EN);
  wire wr_loop = REG_WR && (REG_ADDR == mpgt_pkg::ADDR_GATE_LOOP);
  wire wr_div1 = REG_WR && (REG_ADDR == mpgt_pkg::ADDR_DIV1);
  wire wr_div2 = REG_WR && (REG_ADDR == mpgt_pkg::ADDR_DIV2);
  wire wr_tm1  = REG_WR && (REG_ADDR == mpgt_pkg::ADDR_TIME1);
  wire wr_tm2  = REG_WR && (REG_ADDR == mpgt_pkg::ADDR_TIME2);
  wire wr_sel  = REG_WR && (REG_ADDR == mpgt_pkg::ADDR_PHSEL);

  // Register writes; reserved enable bits are not stored and read as zero.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      gate_phase_enable_reg   <= mpgt_pkg::RST_REG8[3:0];
      gate_loop_reg           <= mpgt_pkg::RST_REG8[3:0];
      loop1_clock_divider_reg <= mpgt_pkg::RST_REG8;
      loop2_clock_divider_reg <= mpgt_pkg::RST_REG8;
      loop1_offtime_delay_reg <= mpgt_pkg::RST_REG8;
      loop2_offtime_delay_reg <= mpgt_pkg::RST_REG8;
      phase_select_reg        <= mpgt_pkg::RST_REG8;
    end else begin
      if (wr_en) begin
        gate_phase_enable_reg <= REG_WDATA[mpgt_pkg::GATE_MSB:0];
      end
      if (wr_loop) begin
        gate_loop_reg <= REG_WDATA[mpgt_pkg::GATE_MSB:0];
      end
      if (wr_div1) begin
        loop1_clock_divider_reg <= REG_WDATA;
      end
      if (wr_div2) begin
        loop2_clock_divider_reg <= REG_WDATA;
      end
      if (wr_tm1) begin
        loop1_offtime_delay_reg <= REG_WDATA;
      end
      if (wr_tm2) begin
        loop2_offtime_delay_reg <= REG_WDATA;
      end
      if (wr_sel) begin
        phase_select_reg <= REG_WDATA;
      end
    end
  end

  // Registering the answer keeps the read data free of address decode glitches.
  // Read multiplexer; unmapped addresses answer zero.
  logic [7:0] rd_mux;
  always_comb begin
    case (REG_ADDR)
      mpgt_pkg::ADDR_GATE_EN:   rd_mux = {4'h0, gate_phase_enable_reg};
      mpgt_pkg::ADDR_GATE_LOOP: rd_mux = {4'h0, gate_loop_reg};
      mpgt_pkg::ADDR_DIV1:      rd_mux = loop1_clock_divider_reg;
      mpgt_pkg::ADDR_DIV2:      rd_mux = loop2_clock_divider_reg;
      mpgt_pkg::ADDR_TIME1:     rd_mux = loop1_offtime_delay_reg;
      mpgt_pkg::ADDR_TIME2:     rd_mux = loop2_offtime_delay_reg;
      mpgt_pkg::ADDR_PHSEL:     rd_mux = phase_select_reg;
      mpgt_pkg::ADDR_STATUS:    rd_mux = {4'h0, gate_reg};
      default:                  rd_mux = mpgt_pkg::READ_NONE;
    endcase
  end

  // Named fields of the timing registers.
  wire [4:0] loop1_interphase_delay =
    loop1_offtime_delay_reg[mpgt_pkg::DELAY_MSB:mpgt_pkg::DELAY_LSB];
  wire [4:0] loop2_interphase_delay =
    loop2_offtime_delay_reg[mpgt_pkg::DELAY_MSB:mpgt_pkg::DELAY_LSB];
  wire [2:0] loop1_off_time = loop1_offtime_delay_reg[mpgt_pkg::OFF_MSB:mpgt_pkg::OFF_LSB];
  wire [2:0] loop2_off_time = loop2_offtime_delay_reg[mpgt_pkg::OFF_MSB:mpgt_pkg::OFF_LSB];

  // A loop with no phases sits idle, which also clears its counters.
  // Each loop runs as many virtual phases as enabled gates it owns.
  wire [2:0] loop1_phases = mpgt_pkg::mpgt_count4(gate_phase_enable_reg & ~gate_loop_reg);
  wire [2:0] loop2_phases = mpgt_pkg::mpgt_count4(gate_phase_enable_reg & gate_loop_reg);

  // Loop timing engines, both clocked by the one shared oscillator.
  logic [3:0] loop1_off;  // Loop 1 virtual phases in their off window.
  logic [3:0] loop2_off;  // Loop 2 virtual phases in their off window.
  logic       loop1_tick; // Loop 1 divided tick.
  logic       loop2_tick; // Loop 2 divided tick.

  mpgt_loop #(.DIV_W(8), .DLY_W(5), .OFF_W(3)) u_loop1 (
    .clk         (CLK),
    .rst_b       (RST_B),
    .divisor     (loop1_clock_divider_reg),
    .delay       (loop1_interphase_delay),
    .off_time    (loop1_off_time),
    .phase_count (loop1_phases),
    .phase_off   (loop1_off),
    .div_tick    (loop1_tick)
  );

  mpgt_loop #(.DIV_W(8), .DLY_W(5), .OFF_W(3)) u_loop2 (
    .clk         (CLK),
    .rst_b       (RST_B),
    .divisor     (loop2_clock_divider_reg),
    .delay       (loop2_interphase_delay),
    .off_time    (loop2_off_time),
    .phase_count (loop2_phases),
    .phase_off   (loop2_off),
    .div_tick    (loop2_tick)
  );

  // The gate flop adds one cycle, so a gate follows its window one edge late.
  // Per-gate routing: pick loop, then virtual phase; unused phases stay off.
  always_comb begin
    for (int g = 0; g < mpgt_pkg::NUM_PHASES; g++) begin
      logic [1:0] virt;
      logic [2:0] cnt;
      logic       off;
      virt = phase_select_reg[2*g +: 2];
      cnt  = gate_loop_reg[g] ? loop2_phases : loop1_phases;
      off  = gate_loop_reg[g] ? loop2_off[virt] : loop1_off[virt];
      gate_next[g] = gate_phase_enable_reg[g] && ({1'b0, virt} < cnt) && !off;
      if (FAIL_SILENT) begin
        gate_next[g] = 1'b0;
      end
    end
  end

  // Gates leave from flops so that the drivers never see decode glitches.
  // Output flops and read answer.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      gate_reg  <= 4'h0;
      rdata_reg <= mpgt_pkg::READ_NONE;
    end else begin
      gate_reg  <= gate_next;
      rdata_reg <= rd_mux;
    end
  end

  assign GATE_OUT  = gate_reg;
  assign REG_RDATA = rdata_reg;

  // All checks below run on the one system clock and sleep during reset.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_gate_disabled_low: assert property (1'b1 |=> (GATE_OUT & ~$past(gate_phase_enable_reg)) == 4'h0)
    else $error("A disabled gate was driven.");
  a_fail_silent_off: assert property (FAIL_SILENT [*2] |=> GATE_OUT == 4'h0)
    else $error("Gates active during fail silent.");
  a_route_off: assert property (gate_phase_enable_reg[0] && !gate_loop_reg[0]
    && loop1_off[phase_select_reg[1:0]] |=> !GATE_OUT[0])
    else $error("Gate 1 on during its routed off window.");
  a_div_write: assert property (wr_div1 |=> loop1_clock_divider_reg == $past(REG_WDATA))
    else $error("Loop 1 divisor write was lost.");
  c_fail_silent: cover property (GATE_OUT != 4'h0 ##1 FAIL_SILENT ##1 GATE_OUT == 4'h0);
  c_two_loops: cover property (loop1_tick && loop2_tick && loop1_phases != 3'h0
    && loop2_phases != 3'h0);

  // Every timing write must land in its register on the very next edge.
  a_div2_write: assert property (wr_div2 |=> loop2_clock_divider_reg == $past(REG_WDATA))
    else $error("Loop 2 divisor write was lost.");
  a_time1_write: assert property (wr_tm1 |=>
    loop1_offtime_delay_reg == $past(REG_WDATA))
    else $error("Loop 1 timing write was lost.");
  a_time2_write: assert property (wr_tm2 |=>
    loop2_offtime_delay_reg == $past(REG_WDATA))
    else $error("Loop 2 timing write was lost.");

  // Fail silent must clear the gates one edge after the request, not two.
  a_fail_one_edge: assert property (FAIL_SILENT |=> GATE_OUT == 4'h0)
    else $error("Gates still active one edge after fail silent.");

  // Reserved enable bits are not stored, so a read of the enables shows them clear.
  a_resv_zero: assert property (REG_ADDR == mpgt_pkg::ADDR_GATE_EN |=>
    REG_RDATA[7:4] == 4'h0)
    else $error("Reserved enable bits read back as set.");

  // A gate routed to a virtual phase that its loop does not run must stay low.
  a_unrouted_low: assert property (({1'b0, phase_select_reg[3:2]}
    >= (gate_loop_reg[1] ? loop2_phases : loop1_phases)) |=> !GATE_OUT[1])
    else $error("Gate 2 driven from a phase that its loop does not run.");
  c_unrouted: cover property (gate_phase_enable_reg[1] && phase_select_reg[3:2] == 2'h1
    && loop1_phases == 3'h1 && !gate_loop_reg[1]);

endmodule

//--- mpgt_top_test.sv
// Self-checking testbench of the phase timing generator with gate driver models.
`timescale 1ns/1ps
module mpgt_top_test;
  logic             CLK;          // System clock.
  logic             RST_B;        // Synchronous reset, active low.
  logic [7:0]       REG_ADDR;     // Register address.
  logic [7:0]       REG_WDATA;    // Write data.
  logic             REG_WR;       // Write strobe.
  logic [7:0]       REG_RDATA;    // Read data.
  logic             FAIL_SILENT;  // Fail silent request.
  logic [3:0]       GATE_OUT;     // Gate drives.
  logic [3:0][31:0] low_len;      // Measured low times.
  logic [3:0][31:0] period;       // Measured periods.
  logic [3:0][31:0] fall_at;      // Last fall stamps.
  int               fails;        // Mismatch count.
  int               comparisons;  // Comparison count.

  // Registers checked after reset, with one unmapped address last.
  localparam logic [7:0] REGS [9] = '{mpgt_pkg::ADDR_GATE_EN, mpgt_pkg::ADDR_GATE_LOOP,
    mpgt_pkg::ADDR_DIV1, mpgt_pkg::ADDR_DIV2, mpgt_pkg::ADDR_TIME1, mpgt_pkg::ADDR_TIME2,
    mpgt_pkg::ADDR_PHSEL, mpgt_pkg::ADDR_STATUS, 8'h30};
  // Single phase cases: divisor, timing field, expected low and period in clocks.
  localparam logic [7:0] CDIV [3] = '{8'h00, 8'h03, 8'hFF};
  localparam logic [7:0] CTIME [3] = '{8'hF8, 8'h4F, 8'h09};
  localparam int CLOW [3] = '{1, 28, 256};
  localparam int CPER [3] = '{32, 40, 512};
  // Periods of the four gates with two phases in each loop.
  localparam int MPER [4] = '{16, 16, 30, 30};

  mpgt_top dut (.CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RDATA(REG_RDATA), .FAIL_SILENT(FAIL_SILENT), .GATE_OUT(GATE_OUT));
  mpgt_gate_drv drv (.clk(CLK), .gate_in(GATE_OUT), .low_len(low_len), .period(period),
    .fall_at(fall_at));

  // The clock toggles every half period of 5 ns.
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compares an eight bit value.
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  // Compares a measured cycle count.
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t count got %0d exp %0d", $time, got, exp);
    end
  endtask

  // Writes one register; the strobe stands for exactly one edge.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(negedge CLK);
    REG_WR = 1'b0;
  endtask

  // Reads one register, whose data arrives one edge after the address.
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge CLK);
    REG_ADDR = a;
    @(negedge CLK);
    check8(REG_RDATA, exp);
  endtask

  // Stops both loops so they restart cleanly, programs them, then writes the enables last.
  task automatic setup(input logic [7:0] en, input logic [7:0] lp, input logic [7:0] sel,
                       input logic [7:0] d1, input logic [7:0] t1, input logic [7:0] d2,
                       input logic [7:0] t2);
    wr_reg(mpgt_pkg::ADDR_GATE_EN, 8'h00);
    wr_reg(mpgt_pkg::ADDR_DIV1, d1);
    wr_reg(mpgt_pkg::ADDR_TIME1, t1);
    wr_reg(mpgt_pkg::ADDR_DIV2, d2);
    wr_reg(mpgt_pkg::ADDR_TIME2, t2);
    wr_reg(mpgt_pkg::ADDR_PHSEL, sel);
    wr_reg(mpgt_pkg::ADDR_GATE_LOOP, lp);
    wr_reg(mpgt_pkg::ADDR_GATE_EN, en);
  endtask

  // Checks that the masked gates never turn on during n cycles.
  task automatic quiet(input logic [3:0] mask, input int n);
    logic [3:0] seen;
    seen = 4'h0;
    repeat (n) begin
      @(negedge CLK);
      seen = seen | (GATE_OUT & mask);
    end
    check8({4'h0, seen}, 8'h00);
  endtask

  // Distance from fall b to fall a, folded into one period.
  function automatic logic [31:0] gap(input logic [31:0] a, input logic [31:0] b, input int p);
    int d;
    d = int'(a) - int'(b);
    return 32'((d % p + p) % p);
  endfunction

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge CLK);
    fails++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    stop_test();
  end

  // Main sequence of register and timing scenarios.
  initial begin
    RST_B = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    REG_WR = 1'b0;
    FAIL_SILENT = 1'b0;
    fails = 0;
    comparisons = 0;
    repeat (12) @(negedge CLK);
    RST_B = 1'b1;
    // Registers clear after reset, and all gates stay off.
    foreach (REGS[i]) expect_reg(REGS[i], 8'h00);
    quiet(4'hF, 50);
    wr_reg(mpgt_pkg::ADDR_GATE_EN, 8'h0F);
    expect_reg(mpgt_pkg::ADDR_GATE_EN, 8'h0F);
    wr_reg(8'h30, 8'hA5);
    expect_reg(8'h30, 8'h00);
    // One gate in one loop at a time; the idle loop keeps a different divisor.
    for (int lp = 0; lp < 2; lp++) begin
      foreach (CDIV[i]) begin
        if (lp == 0)
          setup(8'h01, 8'h00, 8'h00, CDIV[i], CTIME[i], 8'h05, 8'h00);
        else
          setup(8'h02, 8'h02, 8'h00, 8'h05, 8'h00, CDIV[i], CTIME[i]);
        repeat (3 * CPER[i] + 20) @(negedge CLK);
        check32(low_len[lp], CLOW[i]);
        check32(period[lp], CPER[i]);
      end
    end
    // Two phases in each loop, both loops running together.
    setup(8'h0F, 8'h0C, 8'h44, 8'h01, 8'h1A, 8'h02, 8'h21);
    repeat (120) @(negedge CLK);
    foreach (MPER[g]) check32(period[g], MPER[g]);
    check32(gap(fall_at[1], fall_at[0], 16), 32'd8);
    check32(gap(fall_at[3], fall_at[2], 30), 32'd15);
    // A disabled gate, and a gate routed beyond the phase count, stay low.
    wr_reg(mpgt_pkg::ADDR_GATE_EN, 8'h0E);
    repeat (4) @(negedge CLK);
    quiet(4'h3, 60);
    // Fail silent forces every gate off while registers still answer.
    wr_reg(mpgt_pkg::ADDR_GATE_EN, 8'h0F);
    repeat (40) @(negedge CLK);
    FAIL_SILENT = 1'b1;
    repeat (2) @(negedge CLK);
    quiet(4'hF, 60);
    wr_reg(mpgt_pkg::ADDR_DIV1, 8'h07);
    expect_reg(mpgt_pkg::ADDR_DIV1, 8'h07);
    expect_reg(mpgt_pkg::ADDR_STATUS, 8'h00);
    FAIL_SILENT = 1'b0;
    stop_test();
  end
endmodule
